//--- rtl/nfa_pkg.sv
// shared constants and types for the nand feature access host controller
package nfa_pkg;
   ////////////////////////////////////////////////////////////////////////////
   localparam logic [7:0] CMD_FEAT_WRITE = 8'hef;
   localparam logic [7:0] CMD_FEAT_READ  = 8'hee;
   localparam logic [7:0] FA_SPEED       = 8'h01;
   localparam logic [7:0] FA_DRIVE       = 8'h80;
   localparam logic [7:0] FA_PULLDOWN    = 8'h81;
   localparam logic [7:0] FA_ARRAY_MODE  = 8'h90;
   localparam logic [7:0] ECC_ON         = 8'h08;
   localparam logic [7:0] ECC_OFF        = 8'h00;
   localparam logic [2:0] SPEED_MAX      = 3'h5;
   localparam logic [2:0] SPEED_RST      = 3'h0;
   localparam logic [1:0] LEVEL_RST      = 2'h0;
   ////////////////////////////////////////////////////////////////////////////
   localparam int CLK_NS      = 10;
   localparam int STROBE_NS   = 20;
   localparam int STROBE_CYC  = (STROBE_NS + CLK_NS - 1) / CLK_NS;
   localparam int ADL_NS      = 70;
   localparam int ADL_CYC     = (ADL_NS + CLK_NS - 1) / CLK_NS;
   localparam int WB_NS       = 100;
   localparam int WB_CYC      = (WB_NS + CLK_NS - 1) / CLK_NS;
   localparam int RD_LO_NS    = 60;
   localparam int RD_LO_CYC   = (RD_LO_NS + CLK_NS - 1) / CLK_NS;
   localparam int FEAT_NS     = 1000;
   localparam int FEAT_CYC    = FEAT_NS / CLK_NS;
   localparam int ITC_NS      = 1000;
   localparam int ITC_CYC     = ITC_NS / CLK_NS;
   localparam int CNT_W       = 16;
   ////////////////////////////////////////////////////////////////////////////
   typedef logic [3:0][7:0] nfa_bytes_t;
   typedef struct packed {
      logic ce_n;
      logic cle;
      logic ale;
      logic we_n;
      logic re_n;
   } nfa_pins_t;
   localparam nfa_pins_t PINS_IDLE = '{ce_n: 1'b1, cle: 1'b0, ale: 1'b0,
                                       we_n: 1'b1, re_n: 1'b1};
endpackage : nfa_pkg

//--- rtl/nfa_sync3.sv
// three-stage input synchroniser with agreement filter, one per bit
`timescale 1ns/1ps
`default_nettype none
module nfa_sync3 #(
   parameter int          W     = 1,
   parameter logic [W-1:0] RST_V = '0
) (
   // clock and reset
   input  wire logic         i_sys_clk,
   input  wire logic         i_rst,
   // pins in, filtered level out
   input  wire logic [W-1:0] i_d,
   output logic      [W-1:0] o_q
);
   ////////////////////////////////////////////////////////////////////////////
   genvar b;
   generate
      for (b = 0; b < W; b++) begin : g_bit
         logic s1_ff;
         logic s2_ff;
         logic s3_ff;
         logic q_ff;
         always_ff @(posedge i_sys_clk or posedge i_rst) begin
            if (i_rst) begin
               s1_ff <= RST_V[b];
               s2_ff <= RST_V[b];
               s3_ff <= RST_V[b];
               q_ff  <= RST_V[b];
            end else begin
               s1_ff <= i_d[b];
               s2_ff <= s1_ff;
               s3_ff <= s2_ff;
               // a change counts only once stages two and three agree
               if (s2_ff == s3_ff) begin
                  q_ff <= s3_ff;
               end
            end
         end
         assign o_q[b] = q_ff;
      end
   endgenerate
endmodule : nfa_sync3
`default_nettype wire

//--- rtl/nfa_host.sv
// host-side feature write / feature read sequencer for an asynchronous nand target
`timescale 1ns/1ps
`default_nettype none
module nfa_host (
   // clock and reset
   input  wire logic               i_sys_clk,
   input  wire logic               i_rst,
   // user request
   input  wire logic               i_req,
   input  wire logic               i_is_read,
   input  wire logic [7:0]         i_faddr,
   input  wire nfa_pkg::nfa_bytes_t i_wbytes,
   input  wire logic               i_low_supply,
   input  wire logic [5:0]         i_mode_ok,
   // user answer
   output logic                    o_ready,
   output logic                    o_done,
   output logic                    o_err,
   output nfa_pkg::nfa_bytes_t     o_rbytes,
   output logic [2:0]              o_speed_mode,
   output logic [1:0]              o_drive_level,
   output logic [1:0]              o_pulldown_level,
   output logic                    o_ecc_on,
   // nand pins
   output nfa_pkg::nfa_pins_t      o_pins,
   output logic [7:0]              o_dq,
   output logic                    o_dq_oe,
   input  wire logic [7:0]         i_dq,
   input  wire logic               i_rb_n
);
   ////////////////////////////////////////////////////////////////////////////
   typedef enum logic [3:0] {
      S_IDLE, S_RDY_WAIT, S_CMD_LO, S_CMD_HI, S_ADR_LO, S_ADR_HI, S_ADL_WAIT,
      S_DAT_LO, S_DAT_HI, S_WB_WAIT, S_BUSY, S_RD_LO, S_RD_HI, S_DONE
   } nfa_state_t;

   localparam logic [nfa_pkg::CNT_W-1:0] STB_LIM  = nfa_pkg::CNT_W'(nfa_pkg::STROBE_CYC - 1);
   localparam logic [nfa_pkg::CNT_W-1:0] ADL_LIM  = nfa_pkg::CNT_W'(nfa_pkg::ADL_CYC - 1);
   localparam logic [nfa_pkg::CNT_W-1:0] WB_LIM   = nfa_pkg::CNT_W'(nfa_pkg::WB_CYC - 1);
   localparam logic [nfa_pkg::CNT_W-1:0] RD_LIM   = nfa_pkg::CNT_W'(nfa_pkg::RD_LO_CYC - 1);
   localparam logic [nfa_pkg::CNT_W-1:0] FEAT_LIM = nfa_pkg::CNT_W'(nfa_pkg::FEAT_CYC);
   localparam logic [nfa_pkg::CNT_W-1:0] ITC_LIM  = nfa_pkg::CNT_W'(nfa_pkg::ITC_CYC);

   nfa_state_t                  state_ff;
   logic [nfa_pkg::CNT_W-1:0]   cnt_ff;
   logic [nfa_pkg::CNT_W-1:0]   lim;
   logic [1:0]                  idx_ff;
   logic                        rd_ff;
   logic                        itc_ff;
   logic [7:0]                  faddr_ff;
   nfa_pkg::nfa_bytes_t         wbytes_ff;
   nfa_pkg::nfa_bytes_t         rbytes_ff;
   logic                        done_ff;
   logic                        err_ff;
   logic                        phase_done;
   logic                        bad_req;
   logic                        rb_ok;
   logic [7:0]                  dq_s;
   nfa_pkg::nfa_pins_t          nxt_pins;
   logic [7:0]                  nxt_dq;
   logic                        nxt_dq_oe;

   ////////////////////////////////////////////////////////////////////////////
   // pins from the target are asynchronous to our clock
   nfa_sync3 #(.W(9), .RST_V(9'h100)) u_sync (
      .i_sys_clk (i_sys_clk),
      .i_rst     (i_rst),
      .i_d       ({i_rb_n, i_dq}),
      .o_q       ({rb_ok, dq_s})
   );

   ////////////////////////////////////////////////////////////////////////////
   // refuse writes the target would misread rather than let them reach it
   always_comb begin
      bad_req = 1'b0;
      if (i_faddr != nfa_pkg::FA_SPEED && i_faddr != nfa_pkg::FA_DRIVE &&
          i_faddr != nfa_pkg::FA_PULLDOWN && i_faddr != nfa_pkg::FA_ARRAY_MODE) begin
         bad_req = 1'b1;
      end else if (!i_is_read) begin
         if (i_wbytes[3:1] != 24'h000000) begin
            bad_req = 1'b1;
         end else if (i_faddr == nfa_pkg::FA_SPEED) begin
            if (i_wbytes[0][7:3] != 5'h00 || i_wbytes[0][2:0] > nfa_pkg::SPEED_MAX) begin
               bad_req = 1'b1;
            end else if (!i_mode_ok[i_wbytes[0][2:0]]) begin
               bad_req = 1'b1;
            end else if (i_low_supply && i_wbytes[0][2:0] == nfa_pkg::SPEED_MAX) begin
               bad_req = 1'b1;
            end
         end else if (i_faddr == nfa_pkg::FA_ARRAY_MODE) begin
            bad_req = (i_wbytes[0] != nfa_pkg::ECC_ON && i_wbytes[0] != nfa_pkg::ECC_OFF);
         end else begin
            bad_req = (i_wbytes[0][7:2] != 6'h00);
         end
      end
   end

   always_comb begin
      case (state_ff)
         S_ADL_WAIT: lim = ADL_LIM;
         S_WB_WAIT:  lim = WB_LIM;
         S_BUSY:     lim = itc_ff ? ITC_LIM : FEAT_LIM;
         S_RD_LO:    lim = RD_LIM;
         default:    lim = STB_LIM;
      endcase
   end
   assign phase_done = (cnt_ff == lim);

   ////////////////////////////////////////////////////////////////////////////
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         state_ff  <= S_IDLE;
         cnt_ff    <= '0;
         idx_ff    <= 2'h0;
         rd_ff     <= 1'b0;
         itc_ff    <= 1'b0;
         faddr_ff  <= 8'h00;
         wbytes_ff <= '0;
         done_ff   <= 1'b0;
         err_ff    <= 1'b0;
      end else begin
         done_ff <= 1'b0;
         cnt_ff  <= phase_done ? '0 : cnt_ff + 1'b1;
         case (state_ff)
            S_IDLE: begin
               cnt_ff <= '0;
               idx_ff <= 2'h0;
               if (i_req) begin
                  err_ff    <= bad_req;
                  rd_ff     <= i_is_read;
                  faddr_ff  <= i_faddr;
                  wbytes_ff <= i_wbytes;
                  itc_ff    <= !i_is_read && i_faddr == nfa_pkg::FA_SPEED &&
                               i_wbytes[0][2:0] != o_speed_mode;
                  done_ff   <= bad_req;
                  state_ff  <= bad_req ? S_IDLE : S_RDY_WAIT;
               end
            end
            S_RDY_WAIT: begin
               cnt_ff <= '0;
               if (rb_ok) begin
                  state_ff <= S_CMD_LO;
               end
            end
            S_CMD_LO:   if (phase_done) state_ff <= S_CMD_HI;
            S_CMD_HI:   if (phase_done) state_ff <= S_ADR_LO;
            S_ADR_LO:   if (phase_done) state_ff <= S_ADR_HI;
            S_ADR_HI:   if (phase_done) state_ff <= rd_ff ? S_WB_WAIT : S_ADL_WAIT;
            S_ADL_WAIT: if (phase_done) state_ff <= S_DAT_LO;
            S_DAT_LO:   if (phase_done) state_ff <= S_DAT_HI;
            S_DAT_HI: begin
               if (phase_done) begin
                  idx_ff   <= idx_ff + 2'h1;
                  state_ff <= (idx_ff == 2'h3) ? S_WB_WAIT : S_DAT_LO;
               end
            end
            S_WB_WAIT: if (phase_done) state_ff <= S_BUSY;
            S_BUSY: begin
               // the busy pin or the wait limit ends the wait, so no status read is ever
               // issued and no data output return command is needed
               if (rb_ok || phase_done) begin
                  err_ff   <= !rb_ok;
                  cnt_ff   <= '0;
                  idx_ff   <= 2'h0;
                  state_ff <= rd_ff ? S_RD_LO : S_DONE;
               end
            end
            S_RD_LO:   if (phase_done) state_ff <= S_RD_HI;
            S_RD_HI: begin
               if (phase_done) begin
                  idx_ff   <= idx_ff + 2'h1;
                  state_ff <= (idx_ff == 2'h3) ? S_DONE : S_RD_LO;
               end
            end
            default: begin
               done_ff  <= 1'b1;
               state_ff <= S_IDLE;
            end
         endcase
      end
   end

   // read bytes are taken at the end of the low phase, after the filter settled
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         rbytes_ff <= '0;
      end else if (state_ff == S_RD_LO && phase_done) begin
         rbytes_ff[idx_ff] <= dq_s;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // mirror of the target settings; only power-up reset clears them
   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_speed_mode     <= nfa_pkg::SPEED_RST;
         o_drive_level    <= nfa_pkg::LEVEL_RST;
         o_pulldown_level <= nfa_pkg::LEVEL_RST;
         o_ecc_on         <= 1'b0;
      end else if (state_ff == S_DONE && !err_ff) begin
         if (faddr_ff == nfa_pkg::FA_SPEED) begin
            o_speed_mode <= rd_ff ? rbytes_ff[0][2:0] : wbytes_ff[0][2:0];
         end else if (faddr_ff == nfa_pkg::FA_DRIVE) begin
            o_drive_level <= rd_ff ? rbytes_ff[0][1:0] : wbytes_ff[0][1:0];
         end else if (faddr_ff == nfa_pkg::FA_PULLDOWN) begin
            o_pulldown_level <= rd_ff ? rbytes_ff[0][1:0] : wbytes_ff[0][1:0];
         end else begin
            o_ecc_on <= rd_ff ? (rbytes_ff[0] == nfa_pkg::ECC_ON)
                              : (wbytes_ff[0] == nfa_pkg::ECC_ON);
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   always_comb begin
      nxt_pins  = nfa_pkg::PINS_IDLE;
      nxt_dq    = 8'h00;
      nxt_dq_oe = 1'b0;
      if (state_ff != S_IDLE && state_ff != S_RDY_WAIT && state_ff != S_DONE) begin
         nxt_pins.ce_n = 1'b0;
      end
      case (state_ff)
         S_CMD_LO, S_CMD_HI: begin
            nxt_pins.cle  = 1'b1;
            nxt_pins.we_n = (state_ff == S_CMD_HI);
            nxt_dq        = rd_ff ? nfa_pkg::CMD_FEAT_READ : nfa_pkg::CMD_FEAT_WRITE;
            nxt_dq_oe     = 1'b1;
         end
         S_ADR_LO, S_ADR_HI: begin
            nxt_pins.ale  = 1'b1;
            nxt_pins.we_n = (state_ff == S_ADR_HI);
            nxt_dq        = faddr_ff;
            nxt_dq_oe     = 1'b1;
         end
         S_DAT_LO, S_DAT_HI: begin
            nxt_pins.we_n = (state_ff == S_DAT_HI);
            nxt_dq        = wbytes_ff[idx_ff];
            nxt_dq_oe     = 1'b1;
         end
         S_RD_LO: nxt_pins.re_n = 1'b0;
         default: nxt_dq_oe = 1'b0;
      endcase
   end

   always_ff @(posedge i_sys_clk or posedge i_rst) begin
      if (i_rst) begin
         o_pins  <= nfa_pkg::PINS_IDLE;
         o_dq    <= 8'h00;
         o_dq_oe <= 1'b0;
         o_ready <= 1'b0;
         o_done  <= 1'b0;
         o_err   <= 1'b0;
      end else begin
         o_pins  <= nxt_pins;
         o_dq    <= nxt_dq;
         o_dq_oe <= nxt_dq_oe;
         o_ready <= (state_ff == S_IDLE) && !i_req;
         o_done  <= done_ff;
         o_err   <= done_ff ? err_ff : o_err;
      end
   end
   assign o_rbytes = rbytes_ff;

   ////////////////////////////////////////////////////////////////////////////
   default clocking cb @(posedge i_sys_clk); endclocking
   default disable iff (i_rst);

   sequence s_addr_sent;
      state_ff == S_ADR_HI && phase_done;
   endsequence

   a_idle_before_cmd: assert property (
      state_ff == S_RDY_WAIT && !rb_ok |=> state_ff == S_RDY_WAIT)
      else $error("command started while target busy");
   a_cmd_on_bus: assert property (
      state_ff == S_CMD_LO && !rd_ff |=> o_pins.cle && o_dq_oe && o_dq == 8'hef)
      else $error("feature write command byte not driven");
   a_adl_gap: assert property (
      s_addr_sent and !rd_ff |=> (state_ff == S_ADL_WAIT) [*7] ##1 state_ff == S_DAT_LO)
      else $error("address to data gap wrong");
   a_four_bytes: assert property (
      state_ff == S_DAT_HI && phase_done |=>
      (state_ff == S_WB_WAIT) == ($past(idx_ff) == 2'h3))
      else $error("subfeature byte count wrong");
   a_busy_exit: assert property (
      state_ff == S_BUSY && !rb_ok && !phase_done |=> state_ff == S_BUSY)
      else $error("left busy wait before target ready");
   a_itc_limit: assert property (
      state_ff == S_IDLE && i_req && !bad_req && !i_is_read &&
      i_faddr == nfa_pkg::FA_SPEED && i_wbytes[0][2:0] != o_speed_mode |=> itc_ff)
      else $error("interface change wait not selected");
   a_read_path: assert property (
      s_addr_sent and rd_ff |=> state_ff == S_WB_WAIT)
      else $error("feature read did not go to busy wait");
   a_mode_range: assert property (
      o_speed_mode <= nfa_pkg::SPEED_MAX)
      else $error("timing mode out of range");
   a_mode5_low: assert property (
      state_ff == S_IDLE && i_req && !i_is_read && i_faddr == 8'h01 &&
      i_wbytes[0] == 8'h05 && i_low_supply |=> ##1 o_done && o_err)
      else $error("mode 5 accepted at low supply");
endmodule : nfa_host
`default_nettype wire

//--- sim/nfa_target_model.sv
// behavioural nand target answering feature write and feature read
`timescale 1ns/1ps
`default_nettype none
module nfa_target_model (
   // power cycle and busy length in ns
   input  wire logic               i_por,
   input  wire logic [15:0]        i_busy_ns,
   // nand pins
   input  wire nfa_pkg::nfa_pins_t i_pins,
   input  wire logic [7:0]         i_dq,
   input  wire logic               i_dq_oe,
   output logic [7:0]              o_dq,
   output logic                    o_rb_n,
   // host slips seen and commands counted
   output logic [15:0]             o_viol,
   output logic [15:0]             o_cmds
);
   logic [7:0] feat [256];
   logic [7:0] fa, p1, last;
   logic [1:0] mode;
   int         cnt, bz;
   realtime    t_adr;
   ////////////////////////////////////////
   task automatic hold_busy(input int ns);
      o_rb_n = 1'b0;
      #(ns);
      o_rb_n = 1'b1;
   endtask : hold_busy
   ////////////////////////////////////////
   always @(posedge i_por or posedge i_pins.we_n) begin
      if (i_por) begin
         for (int i = 0; i < 256; i++) feat[i] = 8'h00;
         mode = 2'h0;
         cnt = 0;
         o_viol = 16'h0;
         o_cmds = 16'h0;
         o_rb_n = 1'b1;
         o_dq = 8'ha5;
         last = 8'h5a;
      end else if (!i_pins.ce_n) begin
         if (!i_dq_oe) o_viol = o_viol + 16'h1;
         if (i_pins.cle) begin
            o_cmds = o_cmds + 16'h1;
            if (!o_rb_n) o_viol = o_viol + 16'h1;
            mode = (i_dq == nfa_pkg::CMD_FEAT_WRITE) ? 2'h1 :
                   (i_dq == nfa_pkg::CMD_FEAT_READ) ? 2'h2 : 2'h0;
            if (mode == 2'h0) o_viol = o_viol + 16'h1;
            cnt = 0;
         end else if (i_pins.ale) begin
            fa = i_dq;
            t_adr = $realtime;
            cnt = 0;
            if (mode == 2'h2) begin
               fork
                  hold_busy(int'(i_busy_ns));
               join_none
            end
         end else if (mode == 2'h1 && cnt < 4) begin
            if (cnt == 0 && $realtime - t_adr < nfa_pkg::ADL_NS) o_viol = o_viol + 16'h1;
            if (cnt == 0) p1 = i_dq;
            else if (i_dq != 8'h00) o_viol = o_viol + 16'h1;
            cnt++;
            if (cnt == 4) begin
               // a changed speed mode is the slow interface change case
               bz = int'(i_busy_ns) + ((fa == nfa_pkg::FA_SPEED && p1 != feat[fa]) ? 100 : 0);
               feat[fa] = p1;
               fork
                  hold_busy(bz);
               join_none
            end
         end
      end
   end
   always @(negedge i_pins.re_n) begin
      if (!i_por && !i_pins.ce_n && mode == 2'h2) begin
         if (!o_rb_n) o_viol = o_viol + 16'h1;
         o_dq = (cnt == 0) ? feat[fa] : 8'h00;
         last = o_dq;
         cnt++;
      end
   end
   // released bus shows the inverse so a late sample cannot match by luck
   always @(posedge i_pins.re_n or posedge i_pins.ce_n) o_dq <= #2 ~last;
endmodule : nfa_target_model
`default_nettype wire

//--- sim/nand_feature_access_tb.sv
// self-checking bench for the nand feature access host controller
`timescale 1ns/1ps
`default_nettype none
module nand_feature_access_tb;
   logic                sys_clk, rst, req, is_read, low_supply, ready, done, err, ecc;
   logic                dq_oe, rb_n, rd, acc;
   logic [7:0]          faddr, dq_o, dq_i, fa;
   logic [5:0]          mode_ok;
   logic [2:0]          speed;
   logic [1:0]          drive, pull;
   logic [15:0]         busy_ns, viol, cmds, cmds0;
   nfa_pkg::nfa_bytes_t wbytes, rbytes, wb;
   nfa_pkg::nfa_pins_t  pins;
   logic [7:0]          exp_set [256];
   int                  failures, cmp_count;
   localparam logic [7:0] ADDRS [6] = '{8'h01, 8'h80, 8'h81, 8'h90, 8'h02, 8'hff};
   ////////////////////////////////////////
   nfa_host dut (.i_sys_clk(sys_clk), .i_rst(rst), .i_req(req), .i_is_read(is_read),
      .i_faddr(faddr), .i_wbytes(wbytes), .i_low_supply(low_supply), .i_mode_ok(mode_ok),
      .o_ready(ready), .o_done(done), .o_err(err), .o_rbytes(rbytes), .o_speed_mode(speed),
      .o_drive_level(drive), .o_pulldown_level(pull), .o_ecc_on(ecc), .o_pins(pins),
      .o_dq(dq_o), .o_dq_oe(dq_oe), .i_dq(dq_i), .i_rb_n(rb_n));
   nfa_target_model target (.i_por(rst), .i_busy_ns(busy_ns), .i_pins(pins), .i_dq(dq_o),
      .i_dq_oe(dq_oe), .o_dq(dq_i), .o_rb_n(rb_n), .o_viol(viol), .o_cmds(cmds));
   always #5 sys_clk = ~sys_clk;
   ////////////////////////////////////////
   task automatic check(input logic [31:0] seen, input logic [31:0] want, input string what);
      cmp_count++;
      if (seen !== want) begin
         failures++;
         $display("CHECK FAILED t=%0t %s seen %h expected %h", $time, what, seen, want);
      end
   endtask : check
   task automatic stop_test;
      $display("comparisons %0d mismatches %0d", cmp_count, failures);
      if (failures == 0 && cmp_count > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask : stop_test
   function automatic logic accepted(input logic [7:0] a, input nfa_pkg::nfa_bytes_t w);
      logic [2:0] m;
      m = w[0][2:0];
      if (w[3:1] != 24'h0) return 1'b0;
      case (a)
         8'h01: return w[0][7:3] == 5'h0 && m <= nfa_pkg::SPEED_MAX && mode_ok[m]
                       && !(m == 3'h5 && low_supply);
         8'h80, 8'h81: return w[0][7:2] == 6'h0;
         8'h90: return w[0] == nfa_pkg::ECC_ON || w[0] == nfa_pkg::ECC_OFF;
         default: return 1'b0;
      endcase
   endfunction : accepted
   task automatic check_mirrors;
      check(32'(speed), 32'(exp_set[8'h01][2:0]), "speed mirror");
      check(32'(drive), 32'(exp_set[8'h80][1:0]), "drive mirror");
      check(32'(pull), 32'(exp_set[8'h81][1:0]), "pulldown mirror");
      check(32'(ecc), 32'(exp_set[8'h90][3]), "ecc mirror");
   endtask : check_mirrors
   task automatic do_reset;
      // step off time zero so the target model is already waiting for the edge
      #1;
      rst = 1'b1;
      repeat (5) @(negedge sys_clk);
      check(32'(pins), 32'(nfa_pkg::PINS_IDLE), "idle pins in reset");
      rst = 1'b0;
      foreach (exp_set[i]) exp_set[i] = 8'h00;
      @(negedge sys_clk);
      check(32'(ready), 32'h1, "ready after reset");
      check_mirrors();
   endtask : do_reset
   task automatic txn(input logic r, input logic [7:0] a, input nfa_pkg::nfa_bytes_t w,
                      input logic want_err);
      int n;
      cmds0 = cmds;
      for (n = 0; n < 300 && ready !== 1'b1; n++) @(negedge sys_clk);
      if (ready !== 1'b1) begin
         failures++;
         stop_test();
      end
      req = 1'b1;
      is_read = r;
      faddr = a;
      wbytes = w;
      @(negedge sys_clk);
      req = 1'b0;
      for (n = 0; n < 3000 && done !== 1'b1; n++) @(negedge sys_clk);
      if (done !== 1'b1) begin
         failures++;
         stop_test();
      end
      check(32'(err), 32'(want_err), "error flag");
   endtask : txn
   task automatic set_ok(input logic [7:0] a, input logic [7:0] v);
      wb = '0;
      wb[0] = v;
      txn(1'b0, a, wb, 1'b0);
      exp_set[a] = v;
      check_mirrors();
   endtask : set_ok
   ////////////////////////////////////////
   initial begin
      sys_clk = 1'b0;
      rst = 1'b0;
      req = 1'b0;
      is_read = 1'b0;
      faddr = 8'h00;
      wbytes = '0;
      low_supply = 1'b0;
      mode_ok = 6'h3f;
      busy_ns = 16'd300;
      failures = 0;
      cmp_count = 0;
      void'($urandom(66));
      do_reset();
      for (int v = 0; v < 6; v++) set_ok(8'h01, 8'(v));
      for (int v = 0; v < 4; v++) set_ok(8'h80, 8'(v));
      for (int v = 0; v < 4; v++) set_ok(8'h81, 8'(v));
      set_ok(8'h90, nfa_pkg::ECC_ON);
      set_ok(8'h90, nfa_pkg::ECC_OFF);
      low_supply = 1'b1;
      wb[0] = 8'h05;
      txn(1'b0, 8'h01, wb, 1'b1);
      for (int i = 0; i < 60; i++) begin
         fa = ADDRS[$urandom_range(5)];
         rd = ($urandom_range(2) == 0);
         wb = '0;
         case (fa)
            8'h01: wb[0] = 8'($urandom_range(8));
            8'h90: wb[0] = 8'($urandom_range(2) * 4);
            default: wb[0] = 8'($urandom_range(4));
         endcase
         if ($urandom_range(7) == 0) wb[$urandom_range(3, 1)] = 8'h01;
         low_supply = 1'($urandom);
         mode_ok = 6'($urandom) | 6'h01;
         busy_ns = 16'($urandom_range(800, 100));
         acc = rd ? (fa inside {8'h01, 8'h80, 8'h81, 8'h90}) : accepted(fa, wb);
         txn(rd, fa, wb, !acc);
         if (!acc) check(32'(cmds), 32'(cmds0), "pins quiet on refusal");
         if (acc && rd) check(rbytes, {24'h0, exp_set[fa]}, "read bytes");
         if (acc && !rd) exp_set[fa] = wb[0];
         check_mirrors();
      end
      // target stays busy past the host's wait: next request must hold off
      busy_ns = 16'd2000;
      wb = '0;
      wb[0] = 8'h02;
      txn(1'b0, 8'h80, wb, 1'b1);
      exp_set[8'h80] = 8'h02;
      busy_ns = 16'd300;
      txn(1'b1, 8'h80, wb, 1'b0);
      check(rbytes, 32'h2, "read after long busy");
      do_reset();
      foreach (ADDRS[i]) begin
         if (i < 4) begin
            txn(1'b1, ADDRS[i], wb, 1'b0);
            check(rbytes, 32'h0, "defaults after power cycle");
         end
      end
      check(32'(viol), 32'h0, "target saw a host slip");
      stop_test();
   end
endmodule : nand_feature_access_tb
`default_nettype wire
